// ===== core/acr_map.vh
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
// ==========================================================
// result width and result fifo depth
`define ACR_RES_W 10
`define ACR_FIFO_DEPTH 4
// hold time of the sample charge, in microseconds, at low and high supply
`define ACR_HOLD_LOW_US 700
`define ACR_HOLD_HIGH_US 1500
// serial link states
`define ACR_ST_IDLE 3'h0
`define ACR_ST_CFG0 3'h1
`define ACR_ST_CFG1 3'h2
`define ACR_ST_FMT 3'h3
`define ACR_ST_MSB 3'h4
`define ACR_ST_LSB 3'h5
`define ACR_ST_ZERO 3'h6
`endif

// ===== core/acr_fifo.v
`timescale 1ns/10ps
// ==========================================================
// small flop fifo, valid/ready on both sides
module acr_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // drain side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr;
    reg [AW-1:0] rdPtr;
    reg [AW:0] count;
    wire doWrite = inValid && inReady;
    wire doRead = outValid && outReady;

    assign inReady = (count != DEPTH[AW:0]);
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData = mem[rdPtr];

    // storage, no reset needed on the data
    always @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    // pointers and fill level
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doWrite && !doRead) begin
                count <= count + 1'b1;
            end else if (doRead && !doWrite) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // acr_fifo

// ===== core/acr_serial_readout.v
`timescale 1ns/10ps
`include "acr_map.vh"
// ==========================================================
// serial command and result readout of a two channel converter
module acr_serial_readout (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // serial link pins, sampled into clk
    input wire sclk,
    input wire chipSel_b,
    input wire cmdIn,
    output reg dataOut,
    output reg dataOutEn_b,
    // conversion results from the analog core
    input wire [`ACR_RES_W-1:0] convData,
    input wire convValid,
    output reg convReady,
    // command seen by the analog core
    output reg sampleHold,
    output reg inputModeSelect,
    output reg channelSelect,
    output reg msbOnlyFormatSelect,
    output reg busy
);
    // ==========================================================
    // pin synchronisers
    reg [1:0] sclkSync;
    reg [1:0] csSync;
    reg [1:0] cmdSync;
    reg sclkLast;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclkSync <= 2'h0;
            csSync <= 2'h3;
            cmdSync <= 2'h0;
            sclkLast <= 1'b0;
        end else begin
            sclkSync <= {sclkSync[0], sclk};
            csSync <= {csSync[0], chipSel_b};
            cmdSync <= {cmdSync[0], cmdIn};
            sclkLast <= sclkSync[1];
        end
    end
    wire sclkS = sclkSync[1];
    wire csS = csSync[1];
    wire cmdS = cmdSync[1];
    // edges only count while selected; the idle level (mode 0,0 or 1,1) is irrelevant
    wire riseEdge = !csS && sclkS && !sclkLast;
    wire fallEdge = !csS && !sclkS && sclkLast;

    // ==========================================================
    // result buffer between the analog core and the shifter
    wire fifoValid;
    wire [`ACR_RES_W-1:0] fifoData;
    reg fifoPop;
    reg [2:0] level;
    wire pushNow = convValid && convReady;
    wire [2:0] next_level = level + {2'h0, pushNow} - {2'h0, fifoPop};

    // registered ready from a shadow fill level, so the port comes from a flop
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level <= 3'h0;
            convReady <= 1'b1;
        end else begin
            level <= next_level;
            convReady <= (next_level != 3'h4); // full at four words
        end
    end

    acr_fifo #(
        .WIDTH(`ACR_RES_W),
        .DEPTH(`ACR_FIFO_DEPTH),
        .AW(2)
    ) uFifo (
        .clk(clk),
        .rst_b(rst_b),
        .inValid(pushNow),
        .inReady(),
        .inData(convData),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    // ==========================================================
    // link state machine
    reg [2:0] state;
    reg [3:0] bitCnt;
    reg [`ACR_RES_W-1:0] result;
    reg armed; // set on the first clock after reset, as the cs synchroniser resets to deselected
    reg waitFirstFall; // fmt rise seen, null bit goes out on next fall
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= `ACR_ST_IDLE;
            bitCnt <= 4'h0;
            result <= {`ACR_RES_W{1'b0}};
            armed <= 1'b0;
            waitFirstFall <= 1'b0;
            dataOut <= 1'b0;
            dataOutEn_b <= 1'b1;
            sampleHold <= 1'b0;
            inputModeSelect <= 1'b0;
            channelSelect <= 1'b0;
            msbOnlyFormatSelect <= 1'b0;
            busy <= 1'b0;
            fifoPop <= 1'b0;
        end else begin
            fifoPop <= 1'b0;
            if (csS) begin
                // deselect abandons the frame and floats the output; mode, channel and format outputs keep their values
                armed <= 1'b1;
                state <= `ACR_ST_IDLE;
                dataOutEn_b <= 1'b1;
                sampleHold <= 1'b0;
                busy <= 1'b0;
                waitFirstFall <= 1'b0;
            end else if (armed) begin
                case (state)
                    `ACR_ST_IDLE: begin
                        // zeros before the start bit are simply skipped
                        if (riseEdge && cmdS) begin
                            state <= `ACR_ST_CFG0;
                            busy <= 1'b1;
                        end
                    end
                    `ACR_ST_CFG0: begin
                        if (riseEdge) begin
                            inputModeSelect <= cmdS;
                            sampleHold <= 1'b1; // sampling opens on this rise
                            state <= `ACR_ST_CFG1;
                        end
                    end
                    `ACR_ST_CFG1: begin
                        if (riseEdge) begin
                            channelSelect <= cmdS;
                            state <= `ACR_ST_FMT;
                        end
                    end
                    `ACR_ST_FMT: begin
                        if (riseEdge) begin
                            msbOnlyFormatSelect <= cmdS;
                            waitFirstFall <= 1'b1;
                        end else if (fallEdge && waitFirstFall) begin
                            // sampling ends here; null bit driven low
                            waitFirstFall <= 1'b0;
                            sampleHold <= 1'b0;
                            dataOutEn_b <= 1'b0;
                            dataOut <= 1'b0;
                            result <= fifoValid ? fifoData : {`ACR_RES_W{1'b0}};
                            fifoPop <= fifoValid;
                            bitCnt <= 4'h0;
                            state <= `ACR_ST_MSB;
                        end
                    end
                    `ACR_ST_MSB: begin
                        // one result bit per falling edge, msb first
                        if (fallEdge) begin
                            dataOut <= result[4'h9 - bitCnt];
                            if (bitCnt == 4'h9) begin
                                bitCnt <= 4'h1;
                                state <= msbOnlyFormatSelect ? `ACR_ST_ZERO : `ACR_ST_LSB;
                            end else begin
                                bitCnt <= bitCnt + 4'h1;
                            end
                        end
                    end
                    `ACR_ST_LSB: begin
                        // lsb was the last bit sent, lsb-first word resumes at bit 1
                        if (fallEdge) begin
                            dataOut <= result[bitCnt];
                            if (bitCnt == 4'h9) begin
                                state <= `ACR_ST_ZERO;
                            end else begin
                                bitCnt <= bitCnt + 4'h1;
                            end
                        end
                    end
                    `ACR_ST_ZERO: begin
                        if (fallEdge) begin
                            dataOut <= 1'b0;
                            busy <= 1'b0;
                        end
                    end
                    default: begin
                        state <= `ACR_ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // acr_serial_readout

// ===== tb/acr_serial_readout_asserts.sv
`timescale 1ns/10ps
`include "acr_map.vh"
// ==========================================================
// port checker for the serial readout
module acr_readout_checker (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // link and core side
    input wire sclk,
    input wire chipSel_b,
    input wire cmdIn,
    input wire dataOut,
    input wire dataOutEn_b,
    input wire [`ACR_RES_W-1:0] convData,
    input wire convValid,
    input wire convReady,
    input wire sampleHold,
    input wire inputModeSelect,
    input wire channelSelect,
    input wire msbOnlyFormatSelect,
    input wire busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // link behaviour
    property p_relOut; $rose(chipSel_b) |-> ##[1:6] dataOutEn_b; endproperty
    a_relOut: assert property (p_relOut) else $error("output kept after deselect");
    property p_abortIdle; chipSel_b [*8] |-> !busy; endproperty
    a_abortIdle: assert property (p_abortIdle) else $error("busy while deselected");
    property p_startSel; $rose(busy) |-> !chipSel_b; endproperty
    a_startSel: assert property (p_startSel) else $error("start without select");
    property p_holdBusy; $rose(sampleHold) |-> busy; endproperty
    a_holdBusy: assert property (p_holdBusy) else $error("sampling outside frame");
    property p_holdLen; $rose(sampleHold) |-> sampleHold [*8] ##[1:40] !sampleHold; endproperty
    a_holdLen: assert property (p_holdLen) else $error("sample window length");
    property p_fmtHeld; $fell(sampleHold) |=> $stable(msbOnlyFormatSelect) [*8]; endproperty
    a_fmtHeld: assert property (p_fmtHeld) else $error("format bit moved");
    property p_enFall; $fell(dataOutEn_b) |-> !chipSel_b; endproperty
    a_enFall: assert property (p_enFall) else $error("driving while deselected");
    // output may only move after a falling serial clock
    property p_outStands; (!chipSel_b && sclk) [*4] |=> $stable(dataOut); endproperty
    a_outStands: assert property (p_outStands) else $error("output moved on high clock");
endmodule // acr_readout_checker
bind acr_serial_readout acr_readout_checker chk_u (.clk(clk), .rst_b(rst_b), .sclk(sclk),
    .chipSel_b(chipSel_b), .cmdIn(cmdIn), .dataOut(dataOut), .dataOutEn_b(dataOutEn_b),
    .convData(convData), .convValid(convValid), .convReady(convReady),
    .sampleHold(sampleHold), .inputModeSelect(inputModeSelect),
    .channelSelect(channelSelect), .msbOnlyFormatSelect(msbOnlyFormatSelect), .busy(busy));

// ===== tb/acr_host_model.sv
`timescale 1ns/10ps
// ==========================================================
// byte oriented host master, 200 ns serial clock
module acr_host_model (
    // link outputs
    output logic sclk,
    output logic chipSel_b,
    output logic cmdIn,
    // returned data
    input wire dataOut,
    input wire dataOutEn_b
);
    initial begin
        sclk = 1'b0;
        chipSel_b = 1'b1;
        cmdIn = 1'b0;
    end
    // one frame; 7 ns skew keeps link edges off the system clock edges
    task automatic xfer(input logic cpol, input logic [23:0] cmd, input int nClk,
        output logic [23:0] rx);
        rx = 24'h0;
        #7 sclk = cpol;
        #150 chipSel_b = 1'b0;
        for (int i = 0; i < nClk; i++) begin
            #100 sclk = 1'b0;
            cmdIn = cmd[23-i];
            #100 sclk = 1'b1;
            // a released line reads back inverted, never as a held value
            rx = {rx[22:0], dataOutEn_b ? ~dataOut : dataOut};
        end
        #100 sclk = cpol;
        cmdIn = ~cmdIn;
        #50 chipSel_b = 1'b1;
        #300;
    endtask
endmodule // acr_host_model

// ===== tb/acr_serial_readout_tb_top.sv
`timescale 1ns/10ps
`include "acr_map.vh"
// ==========================================================
// self-checking bench for the serial readout
module acr_serial_readout_tb_top;
    logic clk, rst_b, convValid;
    logic [`ACR_RES_W-1:0] convData;
    logic [23:0] rx;
    wire sclk, chipSel_b, cmdIn, dataOut, dataOutEn_b, convReady;
    wire sampleHold, inputModeSelect, channelSelect, msbOnlyFormatSelect, busy;
    int errTotal = 0;
    int samplesChecked = 0;
`define CHK(what, exp, got) begin samplesChecked++; if ((exp) !== (got)) begin errTotal++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end
    acr_serial_readout dut_u (.clk(clk), .rst_b(rst_b), .sclk(sclk), .chipSel_b(chipSel_b),
        .cmdIn(cmdIn), .dataOut(dataOut), .dataOutEn_b(dataOutEn_b), .convData(convData),
        .convValid(convValid), .convReady(convReady), .sampleHold(sampleHold),
        .inputModeSelect(inputModeSelect), .channelSelect(channelSelect),
        .msbOnlyFormatSelect(msbOnlyFormatSelect), .busy(busy));
    acr_host_model host_u (.sclk(sclk), .chipSel_b(chipSel_b), .cmdIn(cmdIn),
        .dataOut(dataOut), .dataOutEn_b(dataOutEn_b));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ==========================================================
    // helpers
    task automatic wrapUp();
        $display("compared %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // bits 1..8 as they follow the word lsb first
    function automatic logic [7:0] tail(input logic [9:0] d);
        for (int i = 1; i <= 8; i++) tail[8-i] = d[i];
    endfunction
    // hand one word to the fifo, bounded wait on ready
    task automatic push(input logic [9:0] d);
        int n;
        @(posedge clk);
        convData <= d;
        convValid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            if (convReady === 1'b1) begin
                @(posedge clk);
                break;
            end
        end
        convValid <= 1'b0;
        if (n == 50) begin
            errTotal++;
            wrapUp();
        end
    endtask
    // ==========================================================
    // scenarios
    task automatic testFormats();
        logic [3:0] k;
        logic [9:0] d;
        for (int i = 0; i < 16; i++) begin
            k = i[3:0];
            d = 10'h2c9 + 10'(i * 37);
            push(d);
            host_u.xfer(k[3], {2'b01, k[2:0], 19'h0}, 24, rx);
            `CHK("mode", k[2], inputModeSelect);
            `CHK("chan", k[1], channelSelect);
            `CHK("fmt", k[0], msbOnlyFormatSelect);
            `CHK("msb word", {1'b0, d}, rx[18:8]);
            `CHK("low byte", d[7:0], rx[15:8]);
            `CHK("tail", k[0] ? 8'h00 : tail(d), rx[7:0]);
        end
        $display("formats done");
    endtask
    task automatic testPadding();
        push(10'h1b6);
        host_u.xfer(1'b0, {4'b0001, 3'b101, 17'h0}, 24, rx);
        `CHK("padded", {1'b0, 10'h1b6, 6'h00}, rx[16:0]);
        $display("padding done");
    endtask
    task automatic testAbort();
        push(10'h2f0);
        host_u.xfer(1'b0, {5'b01101, 19'h0}, 8, rx);
        `CHK("first bits", 3'b010, rx[2:0]);
        `CHK("busy", 1'b0, busy);
        `CHK("released", 1'b1, dataOutEn_b);
        push(10'h0cd);
        host_u.xfer(1'b1, {5'b01101, 19'h0}, 24, rx);
        `CHK("after abort", 10'h0cd, rx[17:8]);
        $display("abort done");
    endtask
    // fill until refused, then drain in order and once more when empty
    task automatic testFill();
        for (int i = 0; i < `ACR_FIFO_DEPTH; i++) push(10'h301 + 10'(i));
        @(posedge clk);
        `CHK("full", 1'b0, convReady);
        for (int i = 0; i <= `ACR_FIFO_DEPTH; i++) begin
            host_u.xfer(1'b0, {5'b01101, 19'h0}, 16, rx);
            `CHK("drain", i < 4 ? 10'h301 + 10'(i) : 10'h000, rx[9:0]);
        end
        $display("fill done");
    endtask
    initial begin
        rst_b = 1'b0;
        convValid = 1'b0;
        convData = 10'h000;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        testFormats();
        testPadding();
        testAbort();
        testFill();
        wrapUp();
    end
endmodule // acr_serial_readout_tb_top
